// File: hw/gpc_pkg.sv
// Purpose: Constants and carrier types for the general purpose pin page
// Assumes: 125 MHz management clock, 16-bit management registers
// Notes:   Offsets are management register numbers, not byte addresses
package gpc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register numbers and page selection
	localparam logic [4:0]  ADDR_PIN_FUNC   = 5'h0D;
	localparam logic [4:0]  ADDR_PIN_FUNC2  = 5'h0E;
	localparam logic [4:0]  ADDR_PIN_LEVELS = 5'h0F;
	localparam logic [4:0]  ADDR_DRIVE      = 5'h10;
	localparam logic [4:0]  ADDR_DIRECTION  = 5'h11;
	localparam logic [4:0]  ADDR_MAC_LINK   = 5'h13;
	localparam logic [4:0]  ADDR_MUX_SETUP  = 5'h14;
	localparam logic [4:0]  ADDR_RSVD_LAST  = 5'h0C;
	localparam logic [4:0]  ADDR_RSVD_HIGH  = 5'h1E;
	localparam logic [4:0]  ADDR_PAGE_SEL   = 5'h1F;
	localparam logic [15:0] PAGE_GP         = 16'h0010;
	localparam logic [15:0] PAGE_MAIN       = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// Writable masks and reset values
	localparam logic [15:0] MASK_PIN_FUNC   = 16'h0F0F;
	localparam logic [15:0] MASK_PIN_FUNC2  = 16'hF7FF;
	localparam logic [15:0] MASK_GPIO       = 16'h3F33;
	localparam logic [15:0] MASK_MAC_LINK   = 16'hC00F;
	localparam logic [15:0] MASK_MUX_SETUP  = 16'hFE3F;
	localparam logic [15:0] RST_PIN_FUNC    = 16'h0000;
	localparam logic [15:0] RST_PIN_FUNC2   = 16'h2600;
	localparam logic [15:0] RST_GPIO        = 16'h0000;
	localparam logic [15:0] RST_MAC_LINK    = 16'h000F;
	localparam logic [15:0] RST_MUX_SETUP   = 16'h0010;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int FLD_SD0      = 0;
	localparam int FLD_SD1      = 2;
	localparam int FLD_SCL0     = 8;
	localparam int FLD_SCL1     = 10;
	localparam int FLD_SDA      = 0;
	localparam int FLD_FLF      = 2;
	localparam int FLD_LDSV     = 4;
	localparam int FLD_PPS      = 6;
	localparam int FLD_PULSE_EN = 8;
	localparam int FLD_LED_TRI  = 9;
	localparam int FLD_TWI_TRI  = 10;
	localparam int FLD_HOLD_IN  = 11;
	localparam int FLD_HOLD_OUT = 12;
	localparam int FLD_HOLD_OEN = 13;
	localparam int FLD_SPI      = 14;
	localparam int FLD_MAC      = 14;
	localparam int FLD_LF_SRC   = 0;
	localparam int FLD_TWI_ADDR = 9;
	localparam int FLD_TWI_RATE = 4;
	localparam int FLD_MUX_EN   = 0;

	////////////////////////////////////////////////////////////////////////
	// Codes
	localparam logic [1:0] FN_DEDICATED = 2'h0;
	localparam logic [1:0] FN_GPIO      = 2'h3;
	localparam logic [1:0] MAC_SGMII    = 2'h0;
	localparam logic [1:0] MAC_QSGMII   = 2'h1;
	localparam logic [3:0] LF_PORT0     = 4'h0;
	localparam logic [3:0] LF_PORT1     = 4'h1;
	localparam logic [3:0] LF_OFF_MIN   = 4'hC;
	localparam logic [1:0] RATE_50K     = 2'h0;
	localparam logic [1:0] RATE_100K    = 2'h1;
	localparam logic [1:0] RATE_400K    = 2'h2;
	localparam logic [1:0] RATE_2M      = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// Pins
	localparam int          NUM_PINS     = 14;
	localparam int          NUM_LEDS     = 8;
	localparam int          NUM_MUX      = 4;
	localparam logic [13:0] PIN_MASK     = 14'h3F33;
	localparam logic [13:0] TWI_PIN_MASK = 14'h0130;
	localparam int          PIN_FLF      = 9;

	////////////////////////////////////////////////////////////////////////
	// Serial clock rate, one tick per serial clock period
	localparam int CLK_HZ      = 125_000_000;
	localparam int HZ_50K      = 50_000;
	localparam int HZ_100K     = 100_000;
	localparam int HZ_400K     = 400_000;
	localparam int HZ_2M       = 2_000_000;
	localparam logic [11:0] DIV_50K  = 12'(CLK_HZ / HZ_50K);
	localparam logic [11:0] DIV_100K = 12'(CLK_HZ / HZ_100K);
	localparam logic [11:0] DIV_400K = 12'(CLK_HZ / HZ_400K);
	localparam logic [11:0] DIV_2M   = 12'(CLK_HZ / HZ_2M);

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} gpc_mgmt_req_t;

	typedef struct packed {
		logic sel_gpio;
		logic gpio_out;
		logic gpio_dir;
		logic func_out;
		logic func_drive;
		logic float_high;
	} gpc_pad_ctl_t;

endpackage

// File: hw/gpc_sync3.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs asynchronous to i_clk
// Notes:   Output follows only once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module gpc_sync3 #(
	parameter int W = 15
) (
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_level
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] agree;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= i_async;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	assign agree = ~(s2_ff ^ s3_ff);

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_level <= '0;
		end else begin
			o_level <= (agree & s3_ff) | (~agree & o_level);
		end
	end
endmodule // gpc_sync3
`default_nettype wire

// File: hw/gpc_pin_pad.sv
// Purpose: Output stage of one multiplexed pin
// Assumes: Enable is active low, pin levels resolved outside
// Notes:   Float-high lets an external pull-up set the high level
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_pad
	import gpc_pkg::*;
(
	input  wire gpc_pad_ctl_t i_ctl,
	output logic              o_out,
	output logic              o_oe_n
);
	logic drive;

	always_comb begin
		drive  = i_ctl.sel_gpio ? i_ctl.gpio_dir : i_ctl.func_drive;
		o_out  = i_ctl.sel_gpio ? i_ctl.gpio_out : i_ctl.func_out;
		// A high level is released rather than driven when floating
		o_oe_n = ~drive | (i_ctl.float_high & o_out);
	end
endmodule // gpc_pin_pad
`default_nettype wire

// File: hw/gpc_pin_function_ctrl.sv
// Purpose: General purpose page: pin functions, GPIO, mux setup
// Assumes: Management access in the i_clk domain, hard reset i_nrst
// Notes:   Read data appears one cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
module gpc_pin_function_ctrl
	import gpc_pkg::*;
(
	input  wire  logic                i_clk,
	input  wire  logic                i_nrst,
	input  wire  gpc_mgmt_req_t       i_mgmt,
	output logic [15:0]               o_mgmt_rdata,
	output logic                      o_page_active,
	input  wire  logic [NUM_PINS-1:0] i_pin_in,
	output logic [NUM_PINS-1:0]       o_pin_out,
	output logic [NUM_PINS-1:0]       o_pin_oe_n,
	input  wire  logic [NUM_PINS-1:0] i_func_out,
	input  wire  logic [NUM_PINS-1:0] i_func_drive,
	input  wire  logic                i_hold_in,
	output logic                      o_hold_out,
	output logic                      o_hold_oe_n,
	input  wire  logic [NUM_LEDS-1:0] i_led_val,
	output logic [NUM_LEDS-1:0]       o_led_out,
	output logic [NUM_LEDS-1:0]       o_led_oe_n,
	input  wire  logic [1:0]          i_port_link_fail,
	output logic [1:0]                o_mac_mode,
	output logic                      o_qsgmii_sel,
	output logic                      o_pulse13_en,
	input  wire  logic                i_serial_led_en,
	input  wire  logic                i_mux_rw_dir,
	output logic [7:0]                o_serial_addr_byte,
	output logic                      o_serial_rate_tick,
	output logic [NUM_MUX-1:0]        o_mux_port_en
);

	////////////////////////////////////////////////////////////////////////
	// Page select and write decode
	logic [15:0]         page_ff;
	logic [15:0]         pin_func_ff;
	logic [15:0]         pin_func2_ff;
	logic [15:0]         drive_ff;
	logic [15:0]         dir_ff;
	logic [15:0]         mac_link_ff;
	logic [15:0]         mux_setup_ff;
	logic [NUM_PINS:0]   sync_lvl;
	logic [15:0]         pin_levels;
	logic                hold_lvl;
	logic                page_gp;
	logic                wr_gp;
	logic [15:0]         rd_val;

	assign page_gp = (page_ff == PAGE_GP);
	assign wr_gp   = i_mgmt.wr & page_gp;
	assign o_page_active = page_gp;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			page_ff <= PAGE_MAIN;
		end else if (i_mgmt.wr && i_mgmt.addr == ADDR_PAGE_SEL) begin
			page_ff <= i_mgmt.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Page registers; only the hard reset clears them
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pin_func_ff  <= RST_PIN_FUNC;
			pin_func2_ff <= RST_PIN_FUNC2;
			drive_ff     <= RST_GPIO;
			dir_ff       <= RST_GPIO;
			mac_link_ff  <= RST_MAC_LINK;
			mux_setup_ff <= RST_MUX_SETUP;
		end else if (wr_gp) begin
			case (i_mgmt.addr)
				ADDR_PIN_FUNC: begin
					pin_func_ff <= i_mgmt.wdata & MASK_PIN_FUNC;
				end
				ADDR_PIN_FUNC2: begin
					// Readback bit is not storage
					pin_func2_ff <= i_mgmt.wdata & MASK_PIN_FUNC2;
				end
				ADDR_DRIVE: begin
					drive_ff <= i_mgmt.wdata & MASK_GPIO;
				end
				ADDR_DIRECTION: begin
					dir_ff <= i_mgmt.wdata & MASK_GPIO;
				end
				ADDR_MAC_LINK: begin
					mac_link_ff <= i_mgmt.wdata & MASK_MAC_LINK;
				end
				ADDR_MUX_SETUP: begin
					mux_setup_ff <= i_mgmt.wdata & MASK_MUX_SETUP;
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers for GPIO and power-hold pins
	gpc_sync3 #(
		.W (NUM_PINS + 1)
	) u_sync (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_async ({i_hold_in, i_pin_in}),
		.o_level (sync_lvl)
	);

	assign hold_lvl   = sync_lvl[NUM_PINS];
	assign pin_levels = {2'b00, sync_lvl[NUM_PINS-1:0] & PIN_MASK};

	////////////////////////////////////////////////////////////////////////
	// Read path, registered
	always_comb begin
		rd_val = 16'h0000;
		if (page_gp) begin
			case (i_mgmt.addr)
				ADDR_PIN_FUNC:   rd_val = pin_func_ff;
				ADDR_PIN_FUNC2: begin
					rd_val = pin_func2_ff;
					rd_val[FLD_HOLD_IN] = hold_lvl;
				end
				ADDR_PIN_LEVELS: rd_val = pin_levels;
				ADDR_DRIVE:      rd_val = drive_ff;
				ADDR_DIRECTION:  rd_val = dir_ff;
				ADDR_MAC_LINK:   rd_val = mac_link_ff;
				ADDR_MUX_SETUP:  rd_val = mux_setup_ff;
				default:         rd_val = 16'h0000;
			endcase
		end
		if (i_mgmt.addr == ADDR_PAGE_SEL) begin
			rd_val = page_ff;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_mgmt_rdata <= 16'h0000;
		end else if (i_mgmt.rd) begin
			o_mgmt_rdata <= rd_val;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin function selection; reserved codes keep the dedicated function
	logic [NUM_PINS-1:0] sel_gpio;
	logic                lf_off;
	logic                lf_val;

	always_comb begin
		sel_gpio = '0;
		sel_gpio[0]  = pin_func_ff[FLD_SD0+:2] == FN_GPIO;
		sel_gpio[1]  = pin_func_ff[FLD_SD1+:2] == FN_GPIO;
		sel_gpio[4]  = pin_func_ff[FLD_SCL0+:2] == FN_GPIO;
		sel_gpio[5]  = pin_func_ff[FLD_SCL1+:2] == FN_GPIO;
		sel_gpio[8]  = pin_func2_ff[FLD_SDA+:2] == FN_GPIO;
		sel_gpio[9]  = pin_func2_ff[FLD_FLF+:2] == FN_GPIO;
		sel_gpio[10] = pin_func2_ff[FLD_LDSV+:2] == FN_GPIO;
		sel_gpio[11] = pin_func2_ff[FLD_PPS+:2] == FN_GPIO;
		sel_gpio[12] = pin_func2_ff[FLD_SPI+:2] == FN_GPIO;
		sel_gpio[13] = pin_func2_ff[FLD_SPI+:2] == FN_GPIO;
	end

	// Codes 2 to 11 are reserved; treated as disabled like 12 to 15
	always_comb begin
		lf_off = 1'b1;
		lf_val = 1'b0;
		case (mac_link_ff[FLD_LF_SRC+:4])
			LF_PORT0: begin
				lf_off = 1'b0;
				lf_val = i_port_link_fail[0];
			end
			LF_PORT1: begin
				lf_off = 1'b0;
				lf_val = i_port_link_fail[1];
			end
			default: begin
				lf_off = 1'b1;
				lf_val = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Pin output stages
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			if (PIN_MASK[gi]) begin : g_used
				gpc_pad_ctl_t ctl;
				always_comb begin
					ctl.sel_gpio   = sel_gpio[gi];
					ctl.gpio_out   = drive_ff[gi];
					ctl.gpio_dir   = dir_ff[gi];
					ctl.func_out   = (gi == PIN_FLF) ? lf_val : i_func_out[gi];
					ctl.func_drive = (gi == PIN_FLF) ? ~lf_off
						: i_func_drive[gi];
					ctl.float_high = TWI_PIN_MASK[gi] & ~sel_gpio[gi]
						& pin_func2_ff[FLD_TWI_TRI];
				end
				gpc_pin_pad u_pad (
					.i_ctl  (ctl),
					.o_out  (o_pin_out[gi]),
					.o_oe_n (o_pin_oe_n[gi])
				);
			end else begin : g_absent
				assign o_pin_out[gi]  = 1'b0;
				assign o_pin_oe_n[gi] = 1'b1;
			end
		end
		for (gi = 0; gi < NUM_LEDS; gi++) begin : g_led
			gpc_pad_ctl_t ctl;
			always_comb begin
				ctl.sel_gpio   = 1'b0;
				ctl.gpio_out   = 1'b0;
				ctl.gpio_dir   = 1'b0;
				ctl.func_out   = i_led_val[gi];
				ctl.func_drive = 1'b1;
				ctl.float_high = pin_func2_ff[FLD_LED_TRI];
			end
			gpc_pin_pad u_pad (
				.i_ctl  (ctl),
				.o_out  (o_led_out[gi]),
				.o_oe_n (o_led_oe_n[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Power-hold pin and mode outputs
	assign o_hold_oe_n  = pin_func2_ff[FLD_HOLD_OEN];
	assign o_hold_out   = pin_func2_ff[FLD_HOLD_OUT];
	// Sharing with the daisy-chain input is left to software
	assign o_pulse13_en = pin_func2_ff[FLD_PULSE_EN];
	assign o_mac_mode   = mac_link_ff[FLD_MAC+:2];
	assign o_qsgmii_sel = mac_link_ff[FLD_MAC+:2] == MAC_QSGMII;
	assign o_serial_addr_byte = {mux_setup_ff[FLD_TWI_ADDR+:7],
		i_mux_rw_dir};
	assign o_mux_port_en = mux_setup_ff[FLD_MUX_EN+:NUM_MUX]
		& ~{3'b000, i_serial_led_en};

	////////////////////////////////////////////////////////////////////////
	// Serial clock rate divider; a rate change applies to the period in progress
	logic [11:0] rate_div;
	logic [11:0] rate_cnt_ff;

	always_comb begin
		case (mux_setup_ff[FLD_TWI_RATE+:2])
			RATE_50K:  rate_div = DIV_50K;
			RATE_100K: rate_div = DIV_100K;
			RATE_400K: rate_div = DIV_400K;
			RATE_2M:   rate_div = DIV_2M;
			default:   rate_div = DIV_100K;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rate_cnt_ff        <= 12'h000;
			o_serial_rate_tick <= 1'b0;
		end else if (rate_cnt_ff >= rate_div - 12'h001) begin
			rate_cnt_ff        <= 12'h000;
			o_serial_rate_tick <= 1'b1;
		end else begin
			rate_cnt_ff        <= rate_cnt_ff + 12'h001;
			o_serial_rate_tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	chk_page_gate: assert property (
		i_mgmt.wr && !page_gp && i_mgmt.addr == ADDR_DRIVE
		|=> $stable(drive_ff))
		else $error("GPIO output register written off page");
	chk_hold_write: assert property (
		wr_gp && i_mgmt.addr == ADDR_PIN_FUNC2
		|=> o_hold_oe_n == $past(i_mgmt.wdata[FLD_HOLD_OEN])
			&& o_hold_out == $past(i_mgmt.wdata[FLD_HOLD_OUT]))
		else $error("Power-hold pin did not follow write");
	chk_sd0_gpio: assert property (
		pin_func_ff[FLD_SD0+:2] == FN_GPIO
		|-> o_pin_oe_n[0] == ~dir_ff[0] && o_pin_out[0] == drive_ff[0])
		else $error("Pin 0 not under GPIO control");
	chk_lf_disable: assert property (
		!sel_gpio[PIN_FLF] && mac_link_ff[FLD_LF_SRC+:4] >= LF_OFF_MIN
		|-> o_pin_oe_n[PIN_FLF])
		else $error("Link-fail output driven while disabled");
	chk_tick_space: assert property (
		o_serial_rate_tick |=> !o_serial_rate_tick [*8])
		else $error("Serial rate ticks too close");
	chk_rd_page: assert property (
		i_mgmt.rd && i_mgmt.addr == ADDR_PAGE_SEL
		|=> o_mgmt_rdata == $past(page_ff))
		else $error("Page register read mismatch");
	chk_rsvd_read: assert property (
		i_mgmt.rd && i_mgmt.addr <= ADDR_RSVD_LAST
		|=> o_mgmt_rdata == 16'h0000)
		else $error("Reserved register read nonzero");
	chk_mux_port0: assert property (
		i_serial_led_en |-> !o_mux_port_en[0])
		else $error("Mux port 0 enabled with serial LED");
	chk_addr_byte: assert property (
		wr_gp && i_mgmt.addr == ADDR_MUX_SETUP
		|=> o_serial_addr_byte[7:1] == $past(i_mgmt.wdata[15:9]))
		else $error("Address byte not updated");
	chk_led_float: assert property (
		pin_func2_ff[FLD_LED_TRI] && o_led_out[0] |-> o_led_oe_n[0])
		else $error("LED driven high while float set");
	chk_level_sync: assert property (
		$stable(i_pin_in[0]) [*5]
		|-> ##1 pin_levels[0] == $past(i_pin_in[0], 2))
		else $error("Pin level not reflected after settling");

	cov_page_enter: cover property (
		i_mgmt.wr && i_mgmt.addr == ADDR_PAGE_SEL
		&& i_mgmt.wdata == PAGE_GP);
	cov_gpio_out: cover property (sel_gpio[4] && !o_pin_oe_n[4]);
	cov_hold_out: cover property (!o_hold_oe_n && o_hold_out);
	cov_qsgmii: cover property (o_qsgmii_sel);
endmodule // gpc_pin_function_ctrl
`default_nettype wire

// File: test/gpc_board_model.sv
// Purpose: Board-level pins facing the general purpose pin page
// Assumes: A pin the device does not drive shows the board's own level
// Notes:   The bench sets that level; no pull-up is modelled, two-wire pins read ext
`timescale 1ns/100ps
`default_nettype none
module gpc_board_model
	import gpc_pkg::*;
(
	input  wire logic [NUM_PINS-1:0] i_out,
	input  wire logic [NUM_PINS-1:0] i_oe_n,
	input  wire logic [NUM_PINS-1:0] i_ext,
	input  wire logic                i_hold_out,
	input  wire logic                i_hold_oe_n,
	input  wire logic                i_hold_ext,
	output logic      [NUM_PINS-1:0] o_level,
	output logic                     o_hold_level
);
	////////////////////////////////////////////////////////////////////////
	// Device drive wins over the board, so readback shows what is driven
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			o_level[i] = i_oe_n[i] ? i_ext[i] : i_out[i];
		end
		o_hold_level = i_hold_oe_n ? i_hold_ext : i_hold_out;
	end
endmodule // gpc_board_model
`default_nettype wire

// File: test/test_gp_pin_function_and_gpio_ctrl.sv
// Purpose: Self-checking bench for the general purpose pin page
// Assumes: Management strobes one cycle wide, driven 1 ns after the edge
// Notes:   Every bus operation leaves one idle cycle behind it
`timescale 1ns/100ps
`default_nettype none
module test_gp_pin_function_and_gpio_ctrl
	import gpc_pkg::*;
();
	logic                i_clk = 1'b0;
	logic                i_nrst = 1'b0;
	gpc_mgmt_req_t       i_mgmt;
	logic [15:0]         o_mgmt_rdata;
	logic                o_page_active;
	logic [NUM_PINS-1:0] i_pin_in, o_pin_out, o_pin_oe_n, ext;
	logic [NUM_PINS-1:0] i_func_out, i_func_drive;
	logic                i_hold_in, o_hold_out, o_hold_oe_n, hold_ext;
	logic [NUM_LEDS-1:0] i_led_val, o_led_out, o_led_oe_n;
	logic [1:0]          i_port_link_fail, o_mac_mode;
	logic                o_qsgmii_sel, o_pulse13_en;
	logic                i_serial_led_en, i_mux_rw_dir, o_serial_rate_tick;
	logic [7:0]          o_serial_addr_byte;
	logic [NUM_MUX-1:0]  o_mux_port_en;
	int                  n_mismatch = 0;
	int                  num_checks = 0;
	int                  n;
	logic [11:0]         divs [4] = '{DIV_50K, DIV_100K, DIV_400K, DIV_2M};
	logic [4:0]          rsvd [3] = '{5'h00, ADDR_RSVD_LAST, ADDR_RSVD_HIGH};

	always #4 i_clk = ~i_clk;

	gpc_pin_function_ctrl i_dut (
		.i_clk, .i_nrst, .i_mgmt, .o_mgmt_rdata, .o_page_active,
		.i_pin_in, .o_pin_out, .o_pin_oe_n, .i_func_out, .i_func_drive,
		.i_hold_in, .o_hold_out, .o_hold_oe_n, .i_led_val, .o_led_out,
		.o_led_oe_n, .i_port_link_fail, .o_mac_mode, .o_qsgmii_sel,
		.o_pulse13_en, .i_serial_led_en, .i_mux_rw_dir,
		.o_serial_addr_byte, .o_serial_rate_tick, .o_mux_port_en
	);

	gpc_board_model i_board (
		.i_out(o_pin_out), .i_oe_n(o_pin_oe_n), .i_ext(ext),
		.i_hold_out(o_hold_out), .i_hold_oe_n(o_hold_oe_n),
		.i_hold_ext(hold_ext), .o_level(i_pin_in),
		.o_hold_level(i_hold_in)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus and compare tasks
	task automatic step(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Idle cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		i_mgmt = '{1'b1, 1'b0, a, d};
		step(1);
		i_mgmt = '0;
		step(1);
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		i_mgmt = '{1'b0, 1'b1, a, 16'h0000};
		step(1);
		i_mgmt = '0;
		cmp(o_mgmt_rdata, exp);
		step(1);
	endtask

	task automatic wait_tick(output int k);
		k = 0;
		do begin
			step(1);
			k++;
		end while (o_serial_rate_tick !== 1'b1 && k < 3000);
		if (o_serial_rate_tick !== 1'b1) begin
			n_mismatch++;
			$display("ERROR %0t serial rate tick missing", $time);
			final_report();
		end
	endtask

	task automatic final_report;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		i_mgmt = '0;
		ext = 14'h0000;
		hold_ext = 1'b0;
		i_func_out = 14'h0130;
		i_func_drive = 14'h0130;
		i_led_val = 8'hA5;
		i_port_link_fail = 2'b01;
		i_serial_led_en = 1'b0;
		i_mux_rw_dir = 1'b1;
		step(3);
		i_nrst = 1'b1;
		step(1);
		cmp(16'(o_hold_oe_n), 16'h0001);
		cmp(16'(o_led_oe_n), 16'h00A5);
		cmp(16'(o_pin_oe_n & TWI_PIN_MASK), 16'(TWI_PIN_MASK));
		cmp(16'(o_pin_oe_n[PIN_FLF]), 16'h0001);
		// Off-page traffic must neither land nor read back
		wr(ADDR_DRIVE, 16'hFFFF);
		rd(ADDR_DRIVE, 16'h0000);
		cmp(16'(o_page_active), 16'h0000);
		wr(ADDR_PAGE_SEL, PAGE_GP);
		cmp(16'(o_page_active), 16'h0001);
		rd(ADDR_PIN_FUNC, RST_PIN_FUNC);
		rd(ADDR_PIN_FUNC2, RST_PIN_FUNC2);
		rd(ADDR_DRIVE, RST_GPIO);
		rd(ADDR_DIRECTION, RST_GPIO);
		rd(ADDR_MAC_LINK, RST_MAC_LINK);
		rd(ADDR_MUX_SETUP, RST_MUX_SETUP);
		foreach (rsvd[i]) begin
			wr(rsvd[i], 16'hFFFF);
			rd(rsvd[i], 16'h0000);
		end
		// Link-fail source and MAC mode, pin 9 in function mode
		wr(ADDR_MAC_LINK, 16'h0000);
		cmp(16'({o_pin_oe_n[PIN_FLF], o_pin_out[PIN_FLF]}), 16'h0001);
		wr(ADDR_MAC_LINK, 16'h0001);
		cmp(16'({o_pin_oe_n[PIN_FLF], o_pin_out[PIN_FLF]}), 16'h0000);
		wr(ADDR_MAC_LINK, 16'h400C);
		cmp(16'(o_pin_oe_n[PIN_FLF]), 16'h0001);
		cmp(16'({o_mac_mode, o_qsgmii_sel}), 16'h0003);
		wr(ADDR_MAC_LINK, 16'h000F);
		cmp(16'({o_mac_mode, o_qsgmii_sel}), 16'h0000);
		// Drive both levels, hold pin as output, pulse enable on
		wr(ADDR_PIN_FUNC2, 16'h1100);
		cmp(16'(o_pin_oe_n & TWI_PIN_MASK), 16'h0000);
		cmp(16'(o_pin_out & TWI_PIN_MASK), 16'(TWI_PIN_MASK));
		cmp(16'({o_led_oe_n, o_led_out}), 16'h00A5);
		cmp(16'({o_hold_oe_n, o_hold_out, o_pulse13_en}), 16'h0003);
		step(6);
		rd(ADDR_PIN_FUNC2, 16'h1900);
		// Two-wire mux setup and serial LED override
		wr(ADDR_MUX_SETUP, 16'hA01F);
		cmp(16'(o_serial_addr_byte), 16'h00A1);
		cmp(16'(o_mux_port_en), 16'h000F);
		i_mux_rw_dir = 1'b0;
		i_serial_led_en = 1'b1;
		step(1);
		cmp(16'(o_serial_addr_byte), 16'h00A0);
		cmp(16'(o_mux_port_en), 16'h000E);
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_MUX_SETUP, {7'h50, 3'h0, 2'(c), 4'hF});
			wait_tick(n);
			wait_tick(n);
			cmp(16'(n), 16'(divs[c]));
		end
		// All pins to GPIO, pulse enable back off for daisy-chain use
		i_func_drive = 14'h0000;
		wr(ADDR_PIN_FUNC, 16'h0F0F);
		wr(ADDR_PIN_FUNC2, 16'hC0FF);
		cmp(16'(o_pulse13_en), 16'h0000);
		wr(ADDR_DRIVE, 16'hFFFF);
		rd(ADDR_DRIVE, MASK_GPIO);
		wr(ADDR_DRIVE, 16'h1221);
		wr(ADDR_DIRECTION, 16'hFFFF);
		rd(ADDR_DIRECTION, MASK_GPIO);
		cmp(16'(o_pin_out), 16'h1221);
		cmp(16'(o_pin_oe_n), {2'b00, ~PIN_MASK});
		// Reserved codes keep the dedicated function, which is idle now
		wr(ADDR_PIN_FUNC, 16'h0505);
		cmp(16'(o_pin_oe_n & 14'h0033), 16'h0033);
		wr(ADDR_DIRECTION, 16'h0000);
		cmp(16'(o_pin_oe_n), 16'h3FFF);
		ext = 14'h2D12;
		step(6);
		rd(ADDR_PIN_LEVELS, 16'h2D12);
		wr(ADDR_PIN_LEVELS, 16'h0000);
		rd(ADDR_PIN_LEVELS, 16'h2D12);
		// Hard reset in mid-run clears the page and its registers
		i_nrst = 1'b0;
		step(3);
		i_nrst = 1'b1;
		step(1);
		cmp(16'(o_page_active), 16'h0000);
		wr(ADDR_PAGE_SEL, PAGE_GP);
		rd(ADDR_DRIVE, RST_GPIO);
		rd(ADDR_PIN_FUNC2, RST_PIN_FUNC2);
		wr(ADDR_PAGE_SEL, PAGE_MAIN);
		cmp(16'(o_page_active), 16'h0000);
		rd(ADDR_DRIVE, 16'h0000);
		final_report();
	end
endmodule // test_gp_pin_function_and_gpio_ctrl
`default_nettype wire
